/* verilog/motor_pkg.sv */
// Constants, enumerations and converter, measurement and fault structs for the motor drive supervisor.
package motor_pkg;

    // Clock and monitoring timing.
    localparam int CLK_PERIOD_NS   = 100;
    localparam int MON_PERIOD_US   = 50;
    localparam int SPEED_PERIOD_US = 500;
    localparam int MON_CYCLES      = MON_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int CARRIER_PEAK    = MON_CYCLES / 2;
    localparam int STEP_TICKS      = SPEED_PERIOD_US / MON_PERIOD_US;

    // Converter scaling.
    localparam logic [31:0] ADC_FULL    = 32'h0000_0fff;
    localparam logic [11:0] SPD_MID     = 12'h800;
    localparam logic [11:0] SPD_MID_M1  = 12'h7ff;
    localparam logic [31:0] SPD_SPAN    = 32'h0000_07ff;
    localparam logic [31:0] SPD_MAX_RPM = 32'd2700;
    localparam logic [31:0] VBUS_MAX_MV = 32'd111000;
    localparam logic [31:0] I_SPAN_MA   = 32'd20000;
    localparam logic [31:0] I_MAX_MA    = 32'd10000;

    // Protection limits.
    localparam logic [15:0] OC_LIMIT_MA  = 16'd890;
    localparam logic [16:0] OV_LIMIT_MV  = 17'd28000;
    localparam logic [16:0] UV_LIMIT_MV  = 17'd14000;
    localparam logic [15:0] OS_LIMIT_RPM = 16'd3000;

    // Modulation fixed point: factor Q12, phase reference Q11.
    localparam int          M_FRAC   = 12;
    localparam int          REF_FRAC = 11;
    localparam logic [12:0] M_ONE    = 13'h1000;

    typedef enum logic [1:0] {
        SYS_INACTIVE = 2'h0,
        SYS_ACTIVE   = 2'h1,
        SYS_ERROR    = 2'h2
    } sys_e;

    typedef enum logic [1:0] {
        RUN_IDLE   = 2'h0,
        RUN_ALIGN  = 2'h1,
        RUN_OPEN   = 2'h2,
        RUN_CLOSED = 2'h3
    } run_e;

    typedef struct packed {
        logic [11:0] speed_ref;
        logic [11:0] bus_v;
        logic [11:0] iu;
        logic [11:0] iw;
    } adc_s;

    typedef struct packed {
        logic               ccw;
        logic        [11:0] speed_rpm;
        logic        [16:0] vbus_mv;
        logic signed [15:0] iu_ma;
        logic signed [15:0] iw_ma;
    } meas_s;

    typedef struct packed {
        logic ext_oc;
        logic over_current;
        logic over_voltage;
        logic under_voltage;
        logic over_speed;
    } fault_s;

endpackage : motor_pkg

/* verilog/tri_carrier.sv */
// Up/down triangular carrier counter with a valley tick once per period.
`timescale 1ns/1ps
`default_nettype none
module tri_carrier #(
    parameter int PEAK = motor_pkg::CARRIER_PEAK
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Carrier
    output logic      [15:0] carrier_o,
    output logic             valley_o
);
    localparam logic [15:0] PEAK_V = 16'(PEAK);

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        up_reg;
    logic        up_next;

    if (PEAK < 2 || PEAK > 65535) begin : g_chk
        $error("tri_carrier: PEAK out of range");
    end

    always_comb begin
        up_next = up_reg;
        if (up_reg && cnt_reg == PEAK_V) begin
            up_next = 1'b0;
        end else if (!up_reg && cnt_reg == 16'h0) begin
            up_next = 1'b1;
        end
        cnt_next = up_next ? cnt_reg + 16'h1 : cnt_reg - 16'h1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0;
            up_reg  <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            up_reg  <= up_next;
        end
    end

    assign carrier_o = cnt_reg;
    assign valley_o  = (cnt_reg == 16'h0);
endmodule : tri_carrier
`default_nettype wire

/* verilog/seq_divider.sv */
// Sequential restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module seq_divider #(
    parameter int NW = 28,
    parameter int DW = 17
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Request
    input  wire logic          start_i,
    input  wire logic [NW-1:0] num_i,
    input  wire logic [DW-1:0] den_i,
    // Result
    output logic      [NW-1:0] quo_o,
    output logic               done_o
);
    logic [NW-1:0] quo_reg, quo_next;
    logic [DW:0]   rem_reg, rem_next;
    logic [DW-1:0] den_reg, den_next;
    logic [7:0]    cnt_reg, cnt_next;
    logic          done_reg, done_next;
    logic [DW:0]   trial;

    if (NW < 2 || NW > 200 || DW < 1) begin : g_chk
        $error("seq_divider: widths out of range");
    end

    // A zero divisor yields an all-ones quotient, which callers saturate.
    always_comb begin
        quo_next  = quo_reg;
        rem_next  = rem_reg;
        den_next  = den_reg;
        cnt_next  = cnt_reg;
        done_next = 1'b0;
        trial     = {rem_reg[DW-1:0], quo_reg[NW-1]};
        if (start_i) begin
            quo_next = num_i;
            rem_next = '0;
            den_next = den_i;
            cnt_next = 8'(NW);
        end else if (cnt_reg != 8'h0) begin
            cnt_next = cnt_reg - 8'h1;
            if (trial >= {1'b0, den_reg}) begin
                rem_next = trial - {1'b0, den_reg};
                quo_next = {quo_reg[NW-2:0], 1'b1};
            end else begin
                rem_next = trial;
                quo_next = {quo_reg[NW-2:0], 1'b0};
            end
            done_next = (cnt_reg == 8'h1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quo_reg  <= '0;
            rem_reg  <= '0;
            den_reg  <= '0;
            cnt_reg  <= 8'h0;
            done_reg <= 1'b0;
        end else begin
            quo_reg  <= quo_next;
            rem_reg  <= rem_next;
            den_reg  <= den_next;
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign quo_o  = quo_reg;
    assign done_o = done_reg;
endmodule : seq_divider
`default_nettype wire

/* verilog/motor_drive_supervisor.sv */
// Motor drive supervisor: scaling, protection, system state and carrier PWM.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1 - Sample start/stop switch; low requests start, high requests stop.
// RL2 - Clockwise: codes 800h..FFFh map linearly to 0..2700 rpm.
// RL3 - Counter-clockwise: codes 7FFh..000h map linearly to 0..2700 rpm.
// RL4 - Bus voltage code 000h..FFFh maps linearly to 0..111 V.
// RL5 - Phase current codes 000h..FFFh map linearly to -10..+10 A.
// RL6 - PWM output on while compare value exceeds triangular carrier, else off.
// RL7 - Compare value chosen so on-width over carrier period equals duty.
// RL8 - Modulation factor is voltage command over measured bus voltage.
// RL9 - System state has three values: inactive, active and error.
// RL10 - Run sequencing advances step by step only while active.
// RL11 - User events move state; device raises error on any fault.
// RL12 - Hardware over-current stop puts all PWM pins high impedance at once.
// RL13 - Each monitoring cycle, phase current above 0.89 A stops the drive.
// RL14 - Each monitoring cycle, bus voltage above 28 V stops the drive.
// RL15 - Each monitoring cycle, bus voltage below 14 V stops the drive.
// RL16 - Each monitoring cycle, speed above 3000 rpm stops the drive.
// RL17 - Bus voltage abnormality stops PWM on all phases.
// RL18 - Falling edge on external over-current input disables all six outputs.
// RL19 - Error persists, outputs off, until reset event; start ignored meanwhile.
// RL20 - Run sequencing returns to its first step when leaving active.
module motor_drive_supervisor #(
    parameter int PEAK       = motor_pkg::CARRIER_PEAK,
    parameter int STEP_TICKS = motor_pkg::STEP_TICKS
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // User events
    input  wire logic                start_stop_switch_i,
    input  wire logic                ev_reset_i,
    // Converter codes and control inputs
    input  wire motor_pkg::adc_s     adc_i,
    input  wire logic         [15:0] est_speed_i,
    input  wire logic         [15:0] volt_cmd_mv_i,
    input  wire logic  signed [11:0] phase_ref_i [3],
    input  wire logic                ext_overcurrent_input_i,
    // Power stage
    output logic              [5:0]  pwm_o,
    output logic              [5:0]  pwm_oe_o,
    // Status
    output motor_pkg::meas_s         meas_o,
    output motor_pkg::sys_e          sys_state_o,
    output motor_pkg::run_e          run_step_o,
    output motor_pkg::fault_s        fault_o,
    output logic              [12:0] mod_factor_o
);
    localparam int          HALF   = PEAK / 2;
    localparam logic [15:0] PEAK_V = 16'(PEAK);
    localparam logic [7:0]  STEP_V = 8'(STEP_TICKS - 1);

    // The divider needs 29 cycles, so a carrier period must be longer than that.
    if (PEAK < 15 || PEAK > 32767 || STEP_TICKS < 1 || STEP_TICKS > 256) begin : g_chk
        $error("motor_drive_supervisor: parameter out of range");
    end

    logic [15:0] carrier;
    logic        valley;

    tri_carrier #(.PEAK(PEAK)) u_carrier (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .carrier_o (carrier),
        .valley_o  (valley)
    );

    // Measurement scaling, registered every clock.
    motor_pkg::meas_s meas_reg, meas_next;
    logic [11:0]      spd_diff;
    logic [31:0]      spd_t, vbus_t, iu_t, iw_t;

    always_comb begin
        meas_next.ccw = (adc_i.speed_ref < motor_pkg::SPD_MID);
        if (meas_next.ccw) begin
            spd_diff = motor_pkg::SPD_MID_M1 - adc_i.speed_ref; // RL3
        end else begin
            spd_diff = adc_i.speed_ref - motor_pkg::SPD_MID; // RL2
        end
        spd_t  = 32'(spd_diff) * motor_pkg::SPD_MAX_RPM / motor_pkg::SPD_SPAN;
        vbus_t = 32'(adc_i.bus_v) * motor_pkg::VBUS_MAX_MV / motor_pkg::ADC_FULL; // RL4
        iu_t   = 32'(adc_i.iu) * motor_pkg::I_SPAN_MA / motor_pkg::ADC_FULL
                 - motor_pkg::I_MAX_MA; // RL5
        iw_t   = 32'(adc_i.iw) * motor_pkg::I_SPAN_MA / motor_pkg::ADC_FULL
                 - motor_pkg::I_MAX_MA; // RL5
        meas_next.speed_rpm = spd_t[11:0];
        meas_next.vbus_mv   = vbus_t[16:0];
        meas_next.iu_ma     = iu_t[15:0];
        meas_next.iw_ma     = iw_t[15:0];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meas_reg <= '0;
        end else begin
            meas_reg <= meas_next;
        end
    end

    // Protection checks: limits at each carrier valley, external input every clock.
    motor_pkg::sys_e   state_reg, state_next;
    logic [15:0]       iu_abs, iw_abs;
    logic              ext_prev_reg;
    logic              ext_fall;
    motor_pkg::fault_s fault_now, fault_reg, fault_next;
    logic              trip;

    assign iu_abs   = meas_reg.iu_ma[15] ? 16'(-meas_reg.iu_ma) : meas_reg.iu_ma;
    assign iw_abs   = meas_reg.iw_ma[15] ? 16'(-meas_reg.iw_ma) : meas_reg.iw_ma;
    assign ext_fall = ext_prev_reg & ~ext_overcurrent_input_i; // RL18

    always_comb begin
        fault_now.ext_oc        = ext_fall; // RL18
        fault_now.over_current  = valley && (iu_abs > motor_pkg::OC_LIMIT_MA
                                  || iw_abs > motor_pkg::OC_LIMIT_MA); // RL13
        fault_now.over_voltage  = valley && meas_reg.vbus_mv > motor_pkg::OV_LIMIT_MV; // RL14
        fault_now.under_voltage = valley && meas_reg.vbus_mv < motor_pkg::UV_LIMIT_MV; // RL15
        fault_now.over_speed    = valley && est_speed_i > motor_pkg::OS_LIMIT_RPM; // RL16
        trip = |fault_now; // RL11
        fault_next = fault_reg;
        if (state_reg == motor_pkg::SYS_ERROR && ev_reset_i) begin
            fault_next = '0;
        end
        fault_next = fault_next | fault_now;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_reg    <= '0;
            ext_prev_reg <= 1'b1;
        end else begin
            fault_reg    <= fault_next;
            ext_prev_reg <= ext_overcurrent_input_i;
        end
    end

    // System state.
    always_comb begin
        state_next = state_reg;
        if (trip) begin
            state_next = motor_pkg::SYS_ERROR; // RL11
        end else begin
            case (state_reg) // RL9
                motor_pkg::SYS_INACTIVE: begin
                    if (valley && !start_stop_switch_i) begin
                        state_next = motor_pkg::SYS_ACTIVE; // RL1
                    end
                end
                motor_pkg::SYS_ACTIVE: begin
                    if (valley && start_stop_switch_i) begin
                        state_next = motor_pkg::SYS_INACTIVE; // RL1
                    end
                end
                motor_pkg::SYS_ERROR: begin
                    if (ev_reset_i) begin
                        state_next = motor_pkg::SYS_INACTIVE; // RL19
                    end
                end
                default: state_next = motor_pkg::SYS_ERROR;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= motor_pkg::SYS_INACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Run sequencing, one step per speed control period.
    motor_pkg::run_e step_reg, step_next;
    logic [7:0]      tick_reg, tick_next;

    always_comb begin
        step_next = step_reg;
        tick_next = tick_reg;
        if (state_reg != motor_pkg::SYS_ACTIVE) begin
            step_next = motor_pkg::RUN_IDLE; // RL20
            tick_next = 8'h0;
        end else if (valley) begin
            if (tick_reg == STEP_V) begin
                tick_next = 8'h0;
                if (step_reg != motor_pkg::RUN_CLOSED) begin
                    step_next = motor_pkg::run_e'(step_reg + 2'h1); // RL10
                end
            end else begin
                tick_next = tick_reg + 8'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_reg <= motor_pkg::RUN_IDLE;
            tick_reg <= 8'h0;
        end else begin
            step_reg <= step_next;
            tick_reg <= tick_next;
        end
    end

    // Modulation factor from voltage command and measured bus voltage.
    logic [27:0] quo;
    logic        div_done;
    logic [12:0] m_reg, m_next;

    seq_divider #(.NW(28), .DW(17)) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .start_i(valley),
        .num_i  ({volt_cmd_mv_i, 12'h000}),
        .den_i  (meas_reg.vbus_mv),
        .quo_o  (quo),
        .done_o (div_done)
    );

    always_comb begin
        m_next = m_reg;
        if (div_done) begin
            m_next = (quo > 28'(motor_pkg::M_ONE)) ? motor_pkg::M_ONE : quo[12:0]; // RL8
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m_reg <= 13'h0;
        end else begin
            m_reg <= m_next;
        end
    end

    // Per-phase compare values and carrier comparison.
    logic [15:0] cmp_reg [3];
    logic [2:0]  hi_next;
    logic [5:0]  pwm_reg;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        logic signed [47:0] prod;
        logic signed [47:0] cmp_s;
        logic        [15:0] cmp_next;

        // Duty is one half plus m times the reference over two.
        always_comb begin
            prod  = 48'(signed'({1'b0, m_reg})) * 48'(phase_ref_i[p]) * 48'(HALF);
            cmp_s = 48'(HALF) + (prod >>> (motor_pkg::M_FRAC + motor_pkg::REF_FRAC)); // RL7
            cmp_next = cmp_reg[p];
            if (div_done) begin
                if (cmp_s < 0) begin
                    cmp_next = 16'h0;
                end else if (cmp_s > 48'(PEAK)) begin
                    cmp_next = PEAK_V;
                end else begin
                    cmp_next = cmp_s[15:0];
                end
            end
            hi_next[p] = (cmp_reg[p] > carrier); // RL6
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cmp_reg[p] <= 16'(HALF);
            end else begin
                cmp_reg[p] <= cmp_next;
            end
        end
    end

    // Switching stops outside the active state, which covers every fault.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_reg <= 6'h00;
        end else if (state_next == motor_pkg::SYS_ACTIVE) begin
            pwm_reg <= {~hi_next, hi_next}; // RL6
        end else begin
            pwm_reg <= 6'h00; // RL17
        end
    end

    assign pwm_o        = pwm_reg;
    assign pwm_oe_o     = (state_reg == motor_pkg::SYS_ERROR || ext_fall) ? 6'h00 : 6'h3f; // RL12
    assign meas_o       = meas_reg;
    assign sys_state_o  = state_reg;
    assign run_step_o   = step_reg;
    assign fault_o      = fault_reg;
    assign mod_factor_o = m_reg;

    a_hiz_on_fall: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
        ext_fall |-> pwm_oe_o == 6'h00 ##1 pwm_oe_o == 6'h00)
        else $error("outputs not released on external stop");
    a_err_on_fall: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
        ext_fall |=> sys_state_o == motor_pkg::SYS_ERROR && fault_o.ext_oc)
        else $error("external stop did not enter error");
    a_oc_trip: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
        valley && iu_abs > motor_pkg::OC_LIMIT_MA |=> sys_state_o == motor_pkg::SYS_ERROR)
        else $error("over-current not tripped");
    a_ov_trip: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        valley && meas_reg.vbus_mv > motor_pkg::OV_LIMIT_MV |=> fault_o.over_voltage)
        else $error("over-voltage not tripped");
    a_uv_trip: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        valley && meas_reg.vbus_mv < motor_pkg::UV_LIMIT_MV |=> pwm_o == 6'h00)
        else $error("under-voltage left outputs switching");
    a_os_trip: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
        valley && est_speed_i > motor_pkg::OS_LIMIT_RPM |=> fault_o.over_speed)
        else $error("over-speed not tripped");
    a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RL19
        sys_state_o == motor_pkg::SYS_ERROR && !ev_reset_i |=> sys_state_o == motor_pkg::SYS_ERROR)
        else $error("error state left without reset event");
    a_start_low: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        state_reg == motor_pkg::SYS_INACTIVE && valley && !start_stop_switch_i && !trip
        |=> sys_state_o == motor_pkg::SYS_ACTIVE)
        else $error("start request not honoured");
    a_step_home: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
        $fell(state_reg == motor_pkg::SYS_ACTIVE) |=> run_step_o == motor_pkg::RUN_IDLE)
        else $error("run step not returned to idle");
    a_pwm_cmp: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        state_next == motor_pkg::SYS_ACTIVE && cmp_reg[0] > carrier |=> pwm_o[0] && !pwm_o[3])
        else $error("phase output not on above carrier");

    c_active: cover property (@(posedge clk_i) disable iff (rst_i)
        sys_state_o == motor_pkg::SYS_ACTIVE);
    c_closed: cover property (@(posedge clk_i) disable iff (rst_i)
        run_step_o == motor_pkg::RUN_CLOSED);
    c_ext_stop: cover property (@(posedge clk_i) disable iff (rst_i) ext_fall);
    c_recover: cover property (@(posedge clk_i) disable iff (rst_i)
        sys_state_o == motor_pkg::SYS_ERROR ##1 sys_state_o == motor_pkg::SYS_INACTIVE);
endmodule : motor_drive_supervisor
`default_nettype wire

/* verif/power_stage_model.sv */
// Behavioural inverter power stage with its sensing converters and over-current comparator.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    // Sensed levels set by the bench
    input  wire logic [11:0]     ref_code_i,
    input  wire logic [11:0]     bus_code_i,
    input  wire logic [11:0]     iu_code_i,
    input  wire logic [11:0]     iw_code_i,
    input  wire logic            trip_i,
    // Towards the supervisor
    output motor_pkg::adc_s      adc_o,
    output logic                 ext_overcurrent_o
);
    assign adc_o = '{speed_ref: ref_code_i, bus_v: bus_code_i, iu: iu_code_i, iw: iw_code_i};
    // The comparator output idles high and falls when the stage trips.
    assign ext_overcurrent_o = ~trip_i;
endmodule : power_stage_model
`default_nettype wire

/* verif/motor_drive_supervisor_bench.sv */
// Self-checking bench for the motor drive supervisor.
`timescale 1ns/1ps
`default_nettype none
`define check(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module motor_drive_supervisor_bench;
    localparam int          PEAK   = 20;
    localparam int          VAL    = 2 * PEAK + 4;
    localparam logic [11:0] BUS_OK = 12'h375;
    localparam logic [11:0] I_ZERO = 12'h800;
    logic                     clk;
    logic                     rst;
    logic                     start_stop_switch;
    logic                     ev_reset;
    logic              [15:0] est_speed;
    logic              [15:0] volt_cmd;
    logic signed       [11:0] phase_ref [3];
    logic              [11:0] ref_code;
    logic              [11:0] bus_code;
    logic              [11:0] iu_code;
    logic              [11:0] iw_code;
    logic                     oc_trip;
    motor_pkg::adc_s          adc;
    logic                     ext_oc;
    logic              [5:0]  pwm;
    logic              [5:0]  pwm_oe;
    motor_pkg::meas_s         meas;
    motor_pkg::sys_e          sys_state;
    motor_pkg::run_e          run_step;
    motor_pkg::fault_s        fault;
    logic              [12:0] mod_factor;
    int                       errors = 0;
    int                       total_checks = 0;

    power_stage_model u_power_stage_model (.ref_code_i(ref_code), .bus_code_i(bus_code),
        .iu_code_i(iu_code), .iw_code_i(iw_code), .trip_i(oc_trip), .adc_o(adc),
        .ext_overcurrent_o(ext_oc));
    motor_drive_supervisor #(.PEAK(PEAK), .STEP_TICKS(2)) u_motor_drive_supervisor (
        .clk_i(clk), .rst_i(rst), .start_stop_switch_i(start_stop_switch),
        .ev_reset_i(ev_reset), .adc_i(adc), .est_speed_i(est_speed), .volt_cmd_mv_i(volt_cmd),
        .phase_ref_i(phase_ref), .ext_overcurrent_input_i(ext_oc), .pwm_o(pwm),
        .pwm_oe_o(pwm_oe), .meas_o(meas), .sys_state_o(sys_state), .run_step_o(run_step),
        .fault_o(fault), .mod_factor_o(mod_factor));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_state(input motor_pkg::sys_e s, input int lim);
        int n;
        n = 0;
        while (sys_state !== s && n < lim) begin
            tick(1);
            n++;
        end
        `check(sys_state, s)
    endtask : wait_state

    task automatic set_normal();
        bus_code = BUS_OK;
        iu_code = I_ZERO;
        iw_code = I_ZERO;
        ref_code = 12'h900;
        est_speed = 16'h03e8;
        oc_trip = 1'b0;
    endtask : set_normal

    task automatic recover();
        set_normal();
        start_stop_switch = 1'b1;
        tick(2);
        ev_reset = 1'b1;
        tick(1);
        ev_reset = 1'b0;
        wait_state(motor_pkg::SYS_INACTIVE, VAL);
        `check(fault, 5'h00)
    endtask : recover

    task automatic start_drive();
        start_stop_switch = 1'b0;
        wait_state(motor_pkg::SYS_ACTIVE, VAL);
    endtask : start_drive

    task automatic scale_row(input logic [11:0] sp, bus, iu, iw);
        motor_pkg::meas_s e;
        ref_code = sp;
        bus_code = bus;
        iu_code = iu;
        iw_code = iw;
        tick(2);
        e.ccw = (sp < 12'h800);
        e.speed_rpm = 12'(e.ccw ? (int'(12'h7ff - sp) * 2700) / 2047
                                : (int'(sp - 12'h800) * 2700) / 2047);
        e.vbus_mv = 17'((int'(bus) * 111000) / 4095);
        e.iu_ma = 16'((int'(iu) * 20000) / 4095 - 10000);
        e.iw_ma = 16'((int'(iw) * 20000) / 4095 - 10000);
        `check(meas, e)
    endtask : scale_row

    task automatic run_test();
        int hi;
        int mism;
        hi = 0;
        mism = 0;
        start_drive();
        volt_cmd = 16'd12000;
        tick(6 * PEAK);
        `check(mod_factor, 13'((12000 * 4096) / ((885 * 111000) / 4095)))
        for (int k = 0; k < 2 * PEAK; k++) begin
            hi += pwm[0];
            mism += (pwm[3] !== ~pwm[0]);
            tick(1);
        end
        `check(hi, 2 * (PEAK / 2) - 1)
        `check(mism, 0)
        `check(pwm_oe, 6'h3f)
        volt_cmd = 16'd60000;
        tick(6 * PEAK);
        `check(mod_factor, 13'h1000)
        phase_ref = '{12'sh400, 12'sh000, 12'shc00};
        tick(2 * PEAK);
        hi = 0;
        mism = 0;
        for (int k = 0; k < 2 * PEAK; k++) begin
            hi += pwm[0];
            mism += pwm[2];
            tick(1);
        end
        `check(hi, 2 * (3 * PEAK / 4) - 1)
        `check(mism, 2 * (PEAK / 4) - 1)
        for (int k = 0; k < 8 * VAL && run_step !== motor_pkg::RUN_CLOSED; k++) tick(1);
        `check(run_step, motor_pkg::RUN_CLOSED)
        start_stop_switch = 1'b1;
        wait_state(motor_pkg::SYS_INACTIVE, VAL);
        tick(2);
        `check(run_step, motor_pkg::RUN_IDLE)
        `check(pwm, 6'h00)
        $display("test run and modulation done");
    endtask : run_test

    task automatic fault_case(input logic [11:0] bus, iu, input logic [15:0] spd,
                              input logic [4:0] f);
        start_drive();
        bus_code = bus;
        iu_code = iu;
        est_speed = spd;
        wait_state(motor_pkg::SYS_ERROR, VAL);
        `check(fault, f)
        `check(pwm_oe, 6'h00)
        `check(pwm, 6'h00)
        tick(3 * PEAK);
        `check(sys_state, motor_pkg::SYS_ERROR)
        recover();
        $display("test protection case done");
    endtask : fault_case

    task automatic ext_trip_test();
        start_drive();
        oc_trip = 1'b1;
        #1;
        `check(pwm_oe, 6'h00)
        tick(1);
        `check(sys_state, motor_pkg::SYS_ERROR)
        `check(fault, 5'h10)
        recover();
        $display("test external trip done");
    endtask : ext_trip_test

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        final_report();
    end

    initial begin
        rst = 1'b1;
        start_stop_switch = 1'b1;
        ev_reset = 1'b0;
        volt_cmd = 16'h0000;
        phase_ref = '{12'sh000, 12'sh000, 12'sh000};
        set_normal();
        tick(10);
        rst = 1'b0;
        tick(1);
        // Measurements read zero under reset, so the first valley sees an under-voltage.
        `check(sys_state, motor_pkg::SYS_ERROR)
        `check(fault, 5'h02)
        `check(pwm_oe, 6'h00)
        scale_row(12'hfff, 12'hfff, 12'h000, 12'hfff);
        scale_row(12'h000, BUS_OK, I_ZERO, I_ZERO);
        scale_row(12'h900, 12'h000, 12'h8b7, 12'h7ff);
        recover();
        $display("test scaling done");
        run_test();
        fault_case(12'h410, I_ZERO, 16'h03e8, 5'h04);
        fault_case(12'h200, I_ZERO, 16'h03e8, 5'h02);
        fault_case(BUS_OK, 12'h8b7, 16'h03e8, 5'h08);
        fault_case(BUS_OK, I_ZERO, 16'd3001, 5'h01);
        ext_trip_test();
        final_report();
    end
endmodule : motor_drive_supervisor_bench
`default_nettype wire
